// ---- hw/local_region_and_master_window_regs.sv ----
// Purpose: Region descriptor, master window mask and base, with their control logic.
// Assumes: The local bus and register ports are synchronous to mclk.
// Notes: A PCI-side write beats a local-side write to the same register in one cycle.
`timescale 1ns/100ps
module local_region_and_master_window_regs (
    input  wire logic        mclk,
    input  wire logic        rst_b,
    input  wire logic [7:0]  pciAddr,
    input  wire logic        pciWrite,
    input  wire logic        pciRead,
    input  wire logic [31:0] pciWdata,
    output logic      [31:0] pciRdata,
    input  wire logic [7:0]  locAddr,
    input  wire logic        locWrite,
    input  wire logic        locRead,
    input  wire logic [31:0] locWdata,
    output logic      [31:0] locRdata,
    input  wire logic        eepromLoad,
    input  wire logic [31:0] eepromData,
    output logic             extraLongLoad,
    output logic             space0BurstEn,
    input  wire logic        romStart,
    input  wire logic        romLast,
    input  wire logic        transferAck_b,
    input  wire logic        burstTerm_b,
    output logic             romBeat,
    output logic             romDone,
    input  wire logic        dsActive,
    input  wire logic        dsWrite,
    input  wire logic        dsXferDone,
    input  wire logic        dsWriteFifoFull,
    output logic             dsDisconnect,
    output logic             dsHoldReady,
    output logic             dsRetry,
    input  wire logic [31:0] localAddr,
    input  wire logic        localAddrValid,
    output logic             dmHit
);
    logic [31:0] desc;
    logic [31:0] next_desc;
    logic [31:0] winMask;
    logic [31:0] next_winMask;
    logic [31:0] winBase;
    logic [31:0] next_winBase;
    logic [31:0] next_pciRdata;
    logic [31:0] next_locRdata;
    logic        next_extraLongLoad;
    logic        next_space0BurstEn;
    logic        next_dsDisconnect;
    logic        next_dsHoldReady;
    logic        next_dsRetry;
    logic        next_dmHit;
    logic [6:0]  retryCnt;
    logic [6:0]  next_retryCnt;
    logic [6:0]  retryTarget;
    logic        armed;
    logic        ackSeen;
    logic        btermSeen;
    logic [7:0]  armedLen;
    lrw_pkg::reg_sel_e pciSel;
    lrw_pkg::reg_sel_e locSel;

    region_cfg_if romIf ();

    function automatic lrw_pkg::reg_sel_e decode(input logic [7:0] a, input logic [7:0] d,
                                                 input logic [7:0] m, input logic [7:0] b);
        if (a == d) begin
            return lrw_pkg::SEL_DESC;
        end else if (a == m) begin
            return lrw_pkg::SEL_MASK;
        end else if (a == b) begin
            return lrw_pkg::SEL_BASE;
        end
        return lrw_pkg::SEL_NONE;
    endfunction

    function automatic logic [31:0] readReg(input lrw_pkg::reg_sel_e s, input logic [31:0] d,
                                            input logic [31:0] m, input logic [31:0] b);
        unique case (s)
            lrw_pkg::SEL_DESC: return d;
            lrw_pkg::SEL_MASK: return m;
            lrw_pkg::SEL_BASE: return b;
            lrw_pkg::SEL_NONE: return lrw_pkg::ZERO_WORD;
        endcase
    endfunction

    assign pciSel = decode(pciAddr, lrw_pkg::PCI_DESC_OFS, lrw_pkg::PCI_MASK_OFS,
                           lrw_pkg::PCI_BASE_OFS);
    assign locSel = decode(locAddr, lrw_pkg::LOC_DESC_OFS, lrw_pkg::LOC_MASK_OFS,
                           lrw_pkg::LOC_BASE_OFS);

    // Local writes apply first so that a PCI write in the same cycle overrides them.
    always_comb begin
        next_desc    = desc;
        next_winMask = winMask;
        next_winBase = winBase;
        if (locWrite && locSel == lrw_pkg::SEL_DESC) begin
            next_desc = (desc & ~lrw_pkg::DESC_BUS_WR) | (locWdata & lrw_pkg::DESC_BUS_WR);
        end
        if (locWrite && locSel == lrw_pkg::SEL_MASK) begin
            next_winMask = locWdata & lrw_pkg::WIN_HI_MASK;
        end
        if (locWrite && locSel == lrw_pkg::SEL_BASE) begin
            next_winBase = locWdata & lrw_pkg::WIN_HI_MASK;
        end
        if (pciWrite && pciSel == lrw_pkg::SEL_DESC) begin
            next_desc = (desc & ~lrw_pkg::DESC_BUS_WR) | (pciWdata & lrw_pkg::DESC_BUS_WR);
        end
        if (pciWrite && pciSel == lrw_pkg::SEL_MASK) begin
            next_winMask = pciWdata & lrw_pkg::WIN_HI_MASK;
        end
        if (pciWrite && pciSel == lrw_pkg::SEL_BASE) begin
            next_winBase = pciWdata & lrw_pkg::WIN_HI_MASK;
        end
        // The EEPROM load is the only path into the extra long load bit.
        if (eepromLoad) begin
            next_desc = (desc & ~lrw_pkg::DESC_EE_WR) | (eepromData & lrw_pkg::DESC_EE_WR);
        end
        next_pciRdata      = pciRead ? readReg(pciSel, desc, winMask, winBase) : pciRdata;
        next_locRdata      = locRead ? readReg(locSel, desc, winMask, winBase) : locRdata;
        next_extraLongLoad = desc[lrw_pkg::EXTRA_LD_BIT];
        next_space0BurstEn = desc[lrw_pkg::SP0_BURST_BIT];
    end

    // Slave write FIFO policy and retry timer.
    assign retryTarget = 7'(desc[lrw_pkg::RETRY_LSB +: 4]) << lrw_pkg::RETRY_UNIT_LOG2;
    assign armed = dsActive && !dsXferDone && (!dsWrite || desc[lrw_pkg::WR_MODE_BIT]);

    always_comb begin
        next_dsDisconnect = dsActive && dsWrite && dsWriteFifoFull
                            && !desc[lrw_pkg::WR_MODE_BIT];
        next_dsHoldReady  = dsActive && dsWrite && dsWriteFifoFull
                            && desc[lrw_pkg::WR_MODE_BIT];
        next_dsRetry      = armed && ((retryTarget == 7'h00)
                            || (retryCnt + 7'h01 == retryTarget));
        next_retryCnt     = (armed && !next_dsRetry) ? retryCnt + 7'h01 : 7'h00;
        next_dmHit        = localAddrValid
                            && ((localAddr & winMask) == (winBase & winMask));
    end

    always_ff @(posedge mclk or negedge rst_b) begin
        if (!rst_b) begin
            desc          <= lrw_pkg::DESC_RESET;
            winMask       <= lrw_pkg::ZERO_WORD;
            winBase       <= lrw_pkg::ZERO_WORD;
            pciRdata      <= lrw_pkg::ZERO_WORD;
            locRdata      <= lrw_pkg::ZERO_WORD;
            extraLongLoad <= 1'b0;
            space0BurstEn <= 1'b0;
            dsDisconnect  <= 1'b0;
            dsHoldReady   <= 1'b0;
            dsRetry       <= 1'b0;
            retryCnt      <= 7'h00;
            dmHit         <= 1'b0;
            ackSeen       <= 1'b0;
            btermSeen     <= 1'b0;
        end else begin
            desc          <= next_desc;
            winMask       <= next_winMask;
            winBase       <= next_winBase;
            pciRdata      <= next_pciRdata;
            locRdata      <= next_locRdata;
            extraLongLoad <= next_extraLongLoad;
            space0BurstEn <= next_space0BurstEn;
            dsDisconnect  <= next_dsDisconnect;
            dsHoldReady   <= next_dsHoldReady;
            dsRetry       <= next_dsRetry;
            retryCnt      <= next_retryCnt;
            dmHit         <= next_dmHit;
            ackSeen       <= !transferAck_b;
            btermSeen     <= !burstTerm_b;
        end
    end

    // Registering the strobes costs a cycle of latency but keeps pin timing off the pacer.
    assign romIf.waitStates = desc[lrw_pkg::ROM_WAIT_LSB +: 4];
    assign romIf.ackEn      = desc[lrw_pkg::ROM_ACK_BIT];
    assign romIf.btermEn    = desc[lrw_pkg::ROM_LOCAL_BURST_TERMINATE_IN_BIT];
    assign romIf.burstEn    = desc[lrw_pkg::ROM_BURST_BIT];
    assign romIf.start      = romStart;
    assign romIf.last       = romLast;
    assign romIf.ack        = ackSeen;
    assign romIf.local_burst_terminate_in      = btermSeen;
    assign romBeat          = romIf.beat;
    assign romDone          = romIf.done;

    rom_beat_pacer pacer (
        .mclk  (mclk),
        .rst_b (rst_b),
        .cfg   (romIf.pacer)
    );

    // Helper for the retry check: armed cycles since arming or since the last retry.
    always_ff @(posedge mclk or negedge rst_b) begin
        if (!rst_b) begin
            armedLen <= 8'h00;
        end else begin
            armedLen <= !armed ? 8'h00 : (dsRetry ? 8'h01 : armedLen + 8'h01);
        end
    end

    property p_retry_delay;
        @(posedge mclk) disable iff (!rst_b)
            (dsRetry && retryTarget != 7'h00) |-> (armedLen == {1'b0, retryTarget});
    endproperty
    a_retry_delay: assert property (p_retry_delay) else $error("retry delay wrong");

    property p_bus_keeps_extra;
        @(posedge mclk) disable iff (!rst_b)
            !eepromLoad |=> $stable(desc[lrw_pkg::EXTRA_LD_BIT]);
    endproperty
    a_bus_keeps_extra: assert property (p_bus_keeps_extra) else $error("bit 25 bus write");

    property p_sp0_burst;
        @(posedge mclk) disable iff (!rst_b)
            ##1 space0BurstEn == $past(desc[lrw_pkg::SP0_BURST_BIT]);
    endproperty
    a_sp0_burst: assert property (p_sp0_burst) else $error("space 0 burst enable lag");

    property p_full_policy;
        @(posedge mclk) disable iff (!rst_b) (dsActive && dsWrite && dsWriteFifoFull)
            |=> (dsDisconnect != dsHoldReady)
                && (dsHoldReady == $past(desc[lrw_pkg::WR_MODE_BIT]));
    endproperty
    a_full_policy: assert property (p_full_policy) else $error("full FIFO policy wrong");

    property p_window_low_zero;
        @(posedge mclk) disable iff (!rst_b)
            (winMask[15:0] == 16'h0000) && (winBase[15:0] == 16'h0000);
    endproperty
    a_window_low_zero: assert property (p_window_low_zero) else $error("low bits set");

    property p_hit;
        @(posedge mclk) disable iff (!rst_b)
            localAddrValid |=> dmHit == ((($past(localAddr) ^ $past(winBase))
                                          & $past(winMask)) == lrw_pkg::ZERO_WORD);
    endproperty
    a_hit: assert property (p_hit) else $error("window hit wrong");
endmodule

// ---- hw/rom_beat_pacer.sv ----
// Purpose: Paces expansion ROM data beats with wait states, acknowledge and burst end.
// Assumes: start is a one-cycle pulse while idle; inputs are on mclk.
// Notes: beat and done are registered, one cycle after the deciding cycle.
`timescale 1ns/100ps
module rom_beat_pacer (
    input wire logic     mclk,
    input wire logic     rst_b,
    region_cfg_if.pacer  cfg
);
    typedef enum logic {P_IDLE, P_WAIT} pace_e;
    pace_e      state;
    pace_e      next_state;
    logic [3:0] cnt;
    logic [3:0] next_cnt;
    logic       beat;
    logic       next_beat;
    logic       done;
    logic       next_done;
    logic       go;
    logic       stop;
    logic [4:0] gap;
    logic [4:0] next_gap;

    assign go   = (state == P_WAIT) && (cnt == 4'h0) && (!cfg.ackEn || cfg.ack);
    assign stop = cfg.last || !cfg.burstEn || (cfg.btermEn && cfg.local_burst_terminate_in);

    always_comb begin
        next_state = state;
        next_cnt   = cnt;
        next_beat  = 1'b0;
        next_done  = 1'b0;
        unique case (state)
            P_IDLE: begin
                if (cfg.start) begin
                    next_state = P_WAIT;
                    next_cnt   = cfg.waitStates;
                end
            end
            P_WAIT: begin
                if (cnt != 4'h0) begin
                    next_cnt = cnt - 4'h1;
                end else if (go) begin
                    next_beat = 1'b1;
                    next_cnt  = cfg.waitStates;
                    if (stop) begin
                        next_done  = 1'b1;
                        next_state = P_IDLE;
                    end
                end
            end
        endcase
    end

    always_comb begin
        if (cfg.start && state == P_IDLE) begin
            next_gap = 5'h00;
        end else if (beat) begin
            next_gap = 5'h01;
        end else if (gap != 5'h1F) begin
            next_gap = gap + 5'h01;
        end else begin
            next_gap = gap;
        end
    end

    always_ff @(posedge mclk or negedge rst_b) begin
        if (!rst_b) begin
            state <= P_IDLE;
            cnt   <= 4'h0;
            beat  <= 1'b0;
            done  <= 1'b0;
            gap   <= 5'h00;
        end else begin
            state <= next_state;
            cnt   <= next_cnt;
            beat  <= next_beat;
            done  <= next_done;
            gap   <= next_gap;
        end
    end

    assign cfg.beat = beat;
    assign cfg.done = done;

    // A beat never comes sooner than the programmed wait count.
    property p_wait_floor;
        @(posedge mclk) disable iff (!rst_b) beat |-> (gap > {1'b0, cfg.waitStates});
    endproperty
    a_wait_floor: assert property (p_wait_floor) else $error("beat before wait states");

    // With acknowledge ignored, the beat lands exactly after the wait states.
    property p_ack_ignored;
        @(posedge mclk) disable iff (!rst_b)
            (state == P_WAIT && cnt == 4'h0 && !cfg.ackEn) |=> beat;
    endproperty
    a_ack_ignored: assert property (p_ack_ignored) else $error("ack not ignored");

    sequence s_local_burst_terminate_in_seen;
        state == P_WAIT && cnt == 4'h0 && go && cfg.btermEn && cfg.local_burst_terminate_in;
    endsequence
    property p_local_burst_terminate_in_ends;
        @(posedge mclk) disable iff (!rst_b) s_local_burst_terminate_in_seen |=> (done && state == P_IDLE);
    endproperty
    a_local_burst_terminate_in_ends: assert property (p_local_burst_terminate_in_ends) else $error("local_burst_terminate_in did not end burst");

    property p_single_beat;
        @(posedge mclk) disable iff (!rst_b) (go && !cfg.burstEn) |=> done;
    endproperty
    a_single_beat: assert property (p_single_beat) else $error("burst while disabled");
endmodule

// ---- include/lrw_pkg.sv ----
// Purpose: Shared constants for the region descriptor and master window registers.
// Assumes: One local clock, mclk, for every register and sequencer.
// Notes: Offsets are byte offsets on the PCI side and on the local side.
package lrw_pkg;
    localparam logic [7:0]  PCI_DESC_OFS  = 8'h18;
    localparam logic [7:0]  PCI_MASK_OFS  = 8'h1C;
    localparam logic [7:0]  PCI_BASE_OFS  = 8'h20;
    localparam logic [7:0]  LOC_DESC_OFS  = 8'h98;
    localparam logic [7:0]  LOC_MASK_OFS  = 8'h9C;
    localparam logic [7:0]  LOC_BASE_OFS  = 8'hA0;
    localparam logic [31:0] DESC_RESET    = 32'h4040_0000;
    localparam logic [31:0] DESC_BUS_WR   = 32'hFDFC_0000;
    localparam logic [31:0] DESC_EE_WR    = 32'hFFFC_0000;
    localparam logic [31:0] WIN_HI_MASK   = 32'hFFFF_0000;
    localparam logic [31:0] ZERO_WORD     = 32'h0000_0000;
    localparam int          ROM_WAIT_LSB  = 18;
    localparam int          ROM_ACK_BIT   = 22;
    localparam int          ROM_LOCAL_BURST_TERMINATE_IN_BIT = 23;
    localparam int          SP0_BURST_BIT = 24;
    localparam int          EXTRA_LD_BIT  = 25;
    localparam int          ROM_BURST_BIT = 26;
    localparam int          WR_MODE_BIT   = 27;
    localparam int          RETRY_LSB     = 28;
    localparam int          RETRY_UNIT_LOG2 = 3;
    typedef enum logic [1:0] {SEL_NONE, SEL_DESC, SEL_MASK, SEL_BASE} reg_sel_e;
endpackage

// ---- include/region_cfg_if.sv ----
// Purpose: Carries expansion ROM settings and beat handshakes to the beat pacer.
// Assumes: Both ends run on mclk.
// Notes: ack and local_burst_terminate_in are already active high here.
`timescale 1ns/100ps
interface region_cfg_if;
    logic [3:0] waitStates;
    logic       ackEn;
    logic       btermEn;
    logic       burstEn;
    logic       start;
    logic       last;
    logic       ack;
    logic       local_burst_terminate_in;
    logic       beat;
    logic       done;
    modport regs  (output waitStates, ackEn, btermEn, burstEn, start, last, ack, local_burst_terminate_in,
                   input beat, done);
    modport pacer (input waitStates, ackEn, btermEn, burstEn, start, last, ack, local_burst_terminate_in,
                   output beat, done);
endinterface

// ---- tb/lbus_responder.sv ----
// Purpose: Local bus slave that answers expansion ROM beats for the bench.
// Assumes: Runs on mclk; the bench sets the delay and burst-terminate request.
// Notes: A delay of zero never acknowledges, which exposes a pacer that waits wrongly.
`timescale 1ns/100ps
module lbus_responder (
    input  wire logic mclk,
    input  wire logic rst_b,
    input  wire logic romStart,
    input  wire logic romBeat,
    input  wire logic [31:0] ackDelay,
    input  wire logic btermReq,
    output logic      transferAck_b,
    output logic      burstTerm_b
);
    int cnt;
    always_ff @(posedge mclk or negedge rst_b) begin
        if (!rst_b) begin
            cnt           <= 0;
            transferAck_b <= 1'b1;
        end else begin
            transferAck_b <= 1'b1;
            if (romStart || romBeat) begin
                cnt <= ackDelay;
            end else if (cnt == 1) begin
                cnt           <= 0;
                transferAck_b <= 1'b0;
            end else if (cnt > 1) begin
                cnt <= cnt - 1;
            end
        end
    end
    assign burstTerm_b = ~btermReq;
endmodule

// ---- tb/test_local_region_and_master_window_regs.sv ----
// Purpose: Self-checking bench for the region descriptor and master window block.
// Assumes: Inputs change on the rising edge by non-blocking assignment.
// Notes: Outputs are sampled one time unit after an edge so its updates have landed.
`timescale 1ns/100ps
`define CHK(a, e) begin checks++; if ((a) !== (e)) begin fails++; \
    $display("MISMATCH t=%0t got=%h exp=%h", $time, (a), (e)); end end
module test_local_region_and_master_window_regs;
    logic mclk = 1'b0, rst_b = 1'b0;
    logic [7:0] pciAddr = 8'h00, locAddr = 8'h00;
    logic pciWrite = 1'b0, pciRead = 1'b0, locWrite = 1'b0, locRead = 1'b0;
    logic [31:0] pciWdata = 32'h0000_0000, locWdata = 32'h0000_0000, pciRdata, locRdata;
    logic [31:0] eepromData = 32'h0000_0000, localAddr = 32'h0000_0000;
    logic eepromLoad = 1'b0, romStart = 1'b0, romLast = 1'b0, btermReq = 1'b0;
    logic dsActive = 1'b0, dsWrite = 1'b0, dsXferDone = 1'b0, dsWriteFifoFull = 1'b0;
    logic localAddrValid = 1'b0, transferAck_b, burstTerm_b, extraLongLoad, space0BurstEn;
    logic romBeat, romDone, dsDisconnect, dsHoldReady, dsRetry, dmHit;
    int ackDelay = 0, fails = 0, checks = 0, n, b, dn;
    always #5 mclk = ~mclk;
    local_region_and_master_window_regs dut (.mclk(mclk), .rst_b(rst_b), .pciAddr(pciAddr),
        .pciWrite(pciWrite), .pciRead(pciRead), .pciWdata(pciWdata), .pciRdata(pciRdata),
        .locAddr(locAddr), .locWrite(locWrite), .locRead(locRead), .locWdata(locWdata),
        .locRdata(locRdata), .eepromLoad(eepromLoad), .eepromData(eepromData),
        .extraLongLoad(extraLongLoad), .space0BurstEn(space0BurstEn), .romStart(romStart),
        .romLast(romLast), .transferAck_b(transferAck_b), .burstTerm_b(burstTerm_b),
        .romBeat(romBeat), .romDone(romDone), .dsActive(dsActive), .dsWrite(dsWrite),
        .dsXferDone(dsXferDone), .dsWriteFifoFull(dsWriteFifoFull),
        .dsDisconnect(dsDisconnect), .dsHoldReady(dsHoldReady), .dsRetry(dsRetry),
        .localAddr(localAddr), .localAddrValid(localAddrValid), .dmHit(dmHit));
    lbus_responder partner (.mclk(mclk), .rst_b(rst_b), .romStart(romStart),
        .romBeat(romBeat), .ackDelay(ackDelay), .btermReq(btermReq),
        .transferAck_b(transferAck_b), .burstTerm_b(burstTerm_b));
    task automatic wr(input bit loc, input logic [7:0] a, input logic [31:0] d);
        @(posedge mclk);
        if (loc) begin
            locAddr  <= a;
            locWdata <= d;
            locWrite <= 1'b1;
        end else begin
            pciAddr  <= a;
            pciWdata <= d;
            pciWrite <= 1'b1;
        end
        @(posedge mclk);
        locWrite <= 1'b0;
        pciWrite <= 1'b0;
    endtask
    task automatic rd(input bit loc, input logic [7:0] a, input logic [31:0] e);
        @(posedge mclk);
        locAddr <= a;
        pciAddr <= a;
        locRead <= loc;
        pciRead <= !loc;
        @(posedge mclk);
        locRead <= 1'b0;
        pciRead <= 1'b0;
        repeat (2) @(posedge mclk);
        #1;
        `CHK(loc ? locRdata : pciRdata, e)
    endtask
    task automatic startRom;
        @(posedge mclk);
        romStart <= 1'b1;
        @(posedge mclk);
        romStart <= 1'b0;
    endtask
    // Counts edges after the start edge until the first beat, giving up at the limit.
    task automatic waitBeat(input int lim);
        for (n = 1; n <= lim; n++) begin
            @(posedge mclk);
            #1;
            if (romBeat) break;
        end
    endtask
    task automatic beatsIn(input int cyc);
        b = 0;
        dn = 0;
        repeat (cyc) begin
            @(posedge mclk);
            #1;
            b += romBeat;
            dn += romDone;
        end
    endtask
    task automatic waitRetry(input int lim);
        for (n = 1; n <= lim; n++) begin
            @(posedge mclk);
            #1;
            if (dsRetry) break;
        end
    endtask
    task automatic testRegs;
        rd(0, 8'h18, lrw_pkg::DESC_RESET);
        rd(1, 8'h9C, lrw_pkg::ZERO_WORD);
        rd(0, 8'h20, lrw_pkg::ZERO_WORD);
        rd(0, 8'h40, lrw_pkg::ZERO_WORD);
        wr(0, 8'h18, 32'hFFFF_FFFF);
        rd(1, 8'h98, lrw_pkg::DESC_BUS_WR);
        @(posedge mclk);
        eepromLoad <= 1'b1;
        eepromData <= 32'h0300_0000;
        @(posedge mclk);
        eepromLoad <= 1'b0;
        repeat (2) @(posedge mclk);
        #1;
        `CHK(extraLongLoad, 1'b1)
        `CHK(space0BurstEn, 1'b1)
        wr(0, 8'h18, 32'h0000_0000);
        rd(0, 8'h18, 32'h0200_0000);
        `CHK(space0BurstEn, 1'b0)
        $display("test registers done");
    endtask
    task automatic testWaits;
        for (int w = 0; w < 16; w += 15) begin
            wr(0, 8'h18, 32'(w) << lrw_pkg::ROM_WAIT_LSB);
            startRom();
            waitBeat(24);
            `CHK(n, w + 1)
            `CHK(romDone, 1'b1)
        end
        ackDelay = 6;
        wr(0, 8'h18, 32'h0040_0000);
        startRom();
        beatsIn(5);
        `CHK(b, 0)
        waitBeat(8);
        `CHK(romBeat, 1'b1)
        ackDelay = 0;
        $display("test wait states done");
    endtask
    task automatic testBurst;
        wr(0, 8'h18, 32'h0404_0000);
        startRom();
        beatsIn(9);
        `CHK(b, 4)
        `CHK(dn, 0)
        @(posedge mclk);
        romLast <= 1'b1;
        beatsIn(4);
        `CHK(dn, 1)
        @(posedge mclk);
        romLast  <= 1'b0;
        btermReq <= 1'b1;
        wr(0, 8'h18, 32'h0484_0000);
        startRom();
        beatsIn(6);
        `CHK(dn, 1)
        wr(0, 8'h18, 32'h0404_0000);
        startRom();
        beatsIn(6);
        `CHK(b, 3)
        `CHK(dn, 0)
        @(posedge mclk);
        romLast <= 1'b1;
        beatsIn(4);
        @(posedge mclk);
        romLast  <= 1'b0;
        btermReq <= 1'b0;
        $display("test burst done");
    endtask
    task automatic testSlave;
        wr(0, 8'h18, 32'h1000_0000);
        @(posedge mclk);
        dsActive <= 1'b1;
        waitRetry(20);
        `CHK(n, 8)
        @(posedge mclk);
        dsWrite <= 1'b1;
        waitRetry(20);
        `CHK(n, 21)
        @(posedge mclk);
        dsWriteFifoFull <= 1'b1;
        repeat (2) @(posedge mclk);
        #1;
        `CHK({dsDisconnect, dsHoldReady}, 2'b10)
        wr(0, 8'h18, 32'h1800_0000);
        repeat (2) @(posedge mclk);
        #1;
        `CHK({dsDisconnect, dsHoldReady}, 2'b01)
        waitRetry(10);
        `CHK(n, 6)
        // A completed transfer disarms the timer, so no retry may follow.
        @(posedge mclk);
        dsXferDone <= 1'b1;
        waitRetry(10);
        `CHK(n, 11)
        @(posedge mclk);
        dsActive        <= 1'b0;
        dsWriteFifoFull <= 1'b0;
        dsXferDone      <= 1'b0;
        $display("test direct slave done");
    endtask
    task automatic chkHit(input logic [31:0] a, input logic e);
        @(posedge mclk);
        localAddr      <= a;
        localAddrValid <= 1'b1;
        repeat (2) @(posedge mclk);
        #1;
        `CHK(dmHit, e)
    endtask
    task automatic testDecode;
        wr(1, 8'h9C, 32'hFFF0_FFFF);
        rd(0, 8'h1C, 32'hFFF0_0000);
        wr(0, 8'h20, 32'h1230_5678);
        rd(1, 8'hA0, 32'h1230_0000);
        chkHit(32'h123F_FFFF, 1'b1);
        chkHit(32'h1240_0000, 1'b0);
        chkHit(32'h1220_0000, 1'b0);
        chkHit(32'h1230_0000, 1'b1);
        $display("test decode done");
    endtask
    task automatic print_verdict;
        $display("checks=%0d fails=%0d", checks, fails);
        if (fails == 0 && checks > 0)
            $display("Test passed");
        else
            $display("Test failed");
        $finish;
    endtask
    initial begin
        repeat (4) @(posedge mclk);
        rst_b <= 1'b1;
        testRegs();
        testWaits();
        testBurst();
        testSlave();
        testDecode();
        print_verdict();
    end
    // The whole sequence needs well under two thousand cycles.
    initial begin
        #100us;
        fails++;
        print_verdict();
    end
endmodule
